// >>> src/clock_tree_and_fast_pll.sv
/*
  Clock distribution gates and the fast peripheral clock loop.
  Assumes the core drives io requests and the sleep mode on SYS_CLK, that
  fuses and the interrupt pin are asynchronous, and that gate outputs drive
  clock gating cells outside this block.
*/
// How it works
// - Core clock runs only while awake.
// - Peripheral clock feeds timers, serial, interrupts.
// - Some interrupts seen with peripheral clock stopped.
// - Program memory clock follows the core clock.
// - Converter clock survives core and peripheral halt.
// - Each domain halts per sleep mode.
// - Fast clock is sixty-four times reference.
// - Reference is RC oscillator divided to 1MHz.
// - Nominal reference gives a 64 MHz clock.
// - Second timer takes fast or prescaled clock.
// - Trim changes move fast clock proportionally.
// - Fast clock saturates at 70 MHz, unlocked.
// - Loop runs on enable bit or fuse.
// - Lock flag sets once loop is locked.
// - Oscillator and loop off in deep sleep.
// - Bit operations only below address 0x20.
// - Fuse zero plus source 0001 selects loop.
`timescale 1ns/1ps
`include "clk_tree_cfg.svh"

module clock_tree_and_fast_pll (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RESET,
  // I/O space access from the core
  input wire clk_tree_pkg::io_request_type IO_REQ,
  output logic [7:0] IO_RDATA,
  // Sleep control and fuses
  input wire clk_tree_pkg::sleep_mode_type SLEEP_MODE,
  input wire logic FAST_CLOCK_SELECT_FUSE,
  input wire logic [3:0] CLOCK_SOURCE_FUSES,
  // External interrupt pin
  input wire logic EXT_INT_N,
  // Distributed clock gates and status
  output clk_tree_pkg::domain_gate_type DOMAIN_GATES,
  output logic SYS_SOURCE_IS_LOOP,
  output logic ASYNC_WAKE,
  output logic EXT_INT_EVENT,
  // Fast clock outputs
  output logic FAST_PERIPHERAL_CLOCK,
  output logic FAST_CLOCK_TICK,
  output logic TIMER1_CLOCK_TICK
);
  import clk_tree_pkg::*;

  // The gate pattern of each sleep mode.
  function automatic domain_gate_type gates_of(input sleep_mode_type mode);
    domain_gate_type g;
    g = '0;
    case (mode)
      SLEEP_ACTIVE: g = '{core: 1'b1, program_memory: 1'b1, peripheral: 1'b1, converter: 1'b1, rc_osc: 1'b1};
      SLEEP_IDLE: g = '{core: 1'b0, program_memory: 1'b0, peripheral: 1'b1, converter: 1'b1, rc_osc: 1'b1};
      SLEEP_ADC_NR: g = '{core: 1'b0, program_memory: 1'b0, peripheral: 1'b0, converter: 1'b1, rc_osc: 1'b1};
      default: g = '0;
    endcase
    return g;
  endfunction

  // Reference word times the loop ratio, wide enough that no product wraps.
  function automatic logic [29:0] mult_word_of(input logic [23:0] ref_word);
    return {6'h00, ref_word} << `FAST_MULT_SHIFT;
  endfunction

  // True once the multiplied word would pass the saturation frequency.
  function automatic logic above_sat(input logic [23:0] ref_word);
    return mult_word_of(ref_word) > {6'h00, `FAST_SAT_WORD};
  endfunction

  // Clamps the multiplied reference word at the saturation frequency.
  function automatic logic [23:0] fast_word_of(input logic [23:0] ref_word);
    logic [29:0] wide;
    wide = mult_word_of(ref_word);
    if (above_sat(ref_word)) begin
      return `FAST_SAT_WORD;
    end
    return wide[23:0];
  endfunction

  domain_gate_type gates;
  logic [1:0] fuse_sync;
  logic [1:0][3:0] source_sync;
  logic [1:0] int_sync;
  logic int_low_prev;
  logic loop_enable_bit;
  logic pck_direct;
  logic [7:0] rc_oscillator_trim;
  logic [23:0] ref_acc;
  logic [23:0] fast_acc;
  logic [23:0] ref_word;
  logic [23:0] fast_word;
  logic [24:0] next_ref_acc;
  logic [24:0] next_fast_acc;
  logic ref_tick;
  logic saturated;
  logic loop_run;
  logic loop_lock_flag;
  loop_state_type loop_state;
  logic [7:0] lock_cnt;
  logic [1:0] prescale_cnt;
  logic ctrl_write;
  logic trim_write;

  // Clock gates are registered so a mode change never glitches a gate.
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      gates <= '{core: 1'b1, program_memory: 1'b1, peripheral: 1'b1, converter: 1'b1, rc_osc: 1'b1};
    end else begin
      gates <= gates_of(SLEEP_MODE);
    end
  end
  assign DOMAIN_GATES = gates;

  // Fuses and the interrupt pin arrive from outside the clock domain.
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      fuse_sync <= '1;
      source_sync <= '1;
      int_sync <= '1;
      int_low_prev <= 1'b0;
    end else begin
      fuse_sync <= {fuse_sync[0], FAST_CLOCK_SELECT_FUSE};
      source_sync <= {source_sync[0], CLOCK_SOURCE_FUSES};
      int_sync <= {int_sync[0], EXT_INT_N};
      int_low_prev <= !int_sync[1];
    end
  end

  // The level wake is taken before any gate, so it works in every sleep mode.
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      ASYNC_WAKE <= 1'b0;
      EXT_INT_EVENT <= 1'b0;
      SYS_SOURCE_IS_LOOP <= 1'b0;
    end else begin
      ASYNC_WAKE <= !int_sync[1];
      EXT_INT_EVENT <= gates.peripheral && !int_sync[1] && !int_low_prev;
      SYS_SOURCE_IS_LOOP <= (fuse_sync[1] == `FUSE_PROGRAMMED) && (source_sync[1] == `SOURCE_FUSES_LOOP);
    end
  end

  // Bit set and clear only reach locations up to 0x1F; both registers of this
  // block sit above that range, so bit operations leave them untouched.
  assign ctrl_write = IO_REQ.wr && (IO_REQ.addr == `ADDR_LOOP_CTRL);
  assign trim_write = IO_REQ.wr && (IO_REQ.addr == `ADDR_RC_TRIM);

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      loop_enable_bit <= `CTRL_RESET;
      pck_direct <= `CTRL_RESET;
    end else if (ctrl_write) begin
      loop_enable_bit <= IO_REQ.wdata[`LOOP_EN_BIT];
      pck_direct <= IO_REQ.wdata[`PCK_DIRECT_BIT];
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      rc_oscillator_trim <= `TRIM_RESET;
    end else if (trim_write) begin
      rc_oscillator_trim <= IO_REQ.wdata;
    end
  end

  // Reserved bits and unmapped locations read as zero.
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      IO_RDATA <= `READ_IDLE;
    end else if (IO_REQ.rd && IO_REQ.addr == `ADDR_LOOP_CTRL) begin
      IO_RDATA <= `READ_IDLE;
      IO_RDATA[`LOCK_BIT] <= loop_lock_flag;
      IO_RDATA[`LOOP_EN_BIT] <= loop_enable_bit;
      IO_RDATA[`PCK_DIRECT_BIT] <= pck_direct;
    end else if (IO_REQ.rd && IO_REQ.addr == `ADDR_RC_TRIM) begin
      IO_RDATA <= rc_oscillator_trim;
    end else begin
      IO_RDATA <= `READ_IDLE;
    end
  end

  // The trimmed oscillator, already divided to its nominal 1 MHz, drives the
  // reference; the fast clock word follows it at once, so trim tracks through.
  assign ref_word = `REF_BASE_WORD + {8'h00, rc_oscillator_trim, 8'h00};
  assign fast_word = fast_word_of(ref_word);
  assign saturated = above_sat(ref_word);
  assign loop_run = (loop_enable_bit || fuse_sync[1] == `FUSE_PROGRAMMED) && gates.rc_osc;
  assign next_ref_acc = {1'b0, ref_acc} + {1'b0, ref_word};
  assign next_fast_acc = {1'b0, fast_acc} + {1'b0, fast_word};
  assign ref_tick = gates.rc_osc && next_ref_acc[24];

  always_ff @(posedge SYS_CLK) begin
    if (RESET || !gates.rc_osc) begin
      ref_acc <= '0;
    end else begin
      ref_acc <= next_ref_acc[23:0];
    end
  end

  // Fast clock: the accumulator top bit is the clock, its carry the tick.
  always_ff @(posedge SYS_CLK) begin
    if (RESET || loop_state == LOOP_OFF) begin
      fast_acc <= '0;
      FAST_CLOCK_TICK <= 1'b0;
    end else begin
      fast_acc <= next_fast_acc[23:0];
      FAST_CLOCK_TICK <= next_fast_acc[24];
    end
  end
  assign FAST_PERIPHERAL_CLOCK = fast_acc[23];

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      loop_state <= LOOP_OFF;
      lock_cnt <= `LOCK_CNT_ZERO;
    end else begin
      case (loop_state)
        LOOP_OFF: begin
          lock_cnt <= `LOCK_CNT_ZERO;
          if (loop_run) begin
            loop_state <= LOOP_ACQUIRE;
          end
        end
        LOOP_ACQUIRE: begin
          if (!loop_run) begin
            loop_state <= LOOP_OFF;
          end else if (saturated) begin
            loop_state <= LOOP_SATURATED;
          end else if (ref_tick) begin
            lock_cnt <= lock_cnt + `LOCK_CNT_ONE;
            if (lock_cnt == `LOCK_REF_TICKS - `LOCK_CNT_ONE) begin
              loop_state <= LOOP_LOCKED;
            end
          end
        end
        LOOP_LOCKED: begin
          if (!loop_run) begin
            loop_state <= LOOP_OFF;
          end else if (saturated) begin
            loop_state <= LOOP_SATURATED;
          end
        end
        LOOP_SATURATED: begin
          lock_cnt <= `LOCK_CNT_ZERO;
          if (!loop_run) begin
            loop_state <= LOOP_OFF;
          end else if (!saturated) begin
            loop_state <= LOOP_ACQUIRE;
          end
        end
        default: begin
          loop_state <= LOOP_OFF;
        end
      endcase
    end
  end
  assign loop_lock_flag = (loop_state == LOOP_LOCKED);

  // Timer clock: either every fast tick or every fourth one.
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      prescale_cnt <= `PRESCALE_ZERO;
      TIMER1_CLOCK_TICK <= 1'b0;
    end else begin
      if (FAST_CLOCK_TICK) begin
        prescale_cnt <= prescale_cnt + `PRESCALE_ONE;
      end
      if (pck_direct) begin
        TIMER1_CLOCK_TICK <= FAST_CLOCK_TICK;
      end else begin
        TIMER1_CLOCK_TICK <= FAST_CLOCK_TICK && (prescale_cnt == `TIMER_PRESCALE_MAX);
      end
    end
  end

  a_core_gated: assert property (@(posedge SYS_CLK) disable iff (RESET)
    SLEEP_MODE != SLEEP_ACTIVE |=> !DOMAIN_GATES.core) else $error("core clock runs in sleep");
  a_flash_with_core: assert property (@(posedge SYS_CLK) disable iff (RESET)
    DOMAIN_GATES.program_memory == DOMAIN_GATES.core) else $error("program memory clock split from core");
  a_converter_kept: assert property (@(posedge SYS_CLK) disable iff (RESET)
    SLEEP_MODE == SLEEP_ADC_NR |=> DOMAIN_GATES.converter && !DOMAIN_GATES.peripheral)
    else $error("converter gating wrong in noise reduction");
  a_deep_sleep_off: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (SLEEP_MODE == SLEEP_POWER_DOWN || SLEEP_MODE == SLEEP_STANDBY) [*2]
    |=> !DOMAIN_GATES.rc_osc && loop_state == LOOP_OFF)
    else $error("oscillator or loop alive in deep sleep");
  a_enable_starts: assert property (@(posedge SYS_CLK) disable iff (RESET)
    loop_state == LOOP_OFF && loop_run |=> loop_state == LOOP_ACQUIRE) else $error("loop did not start");
  a_lock_reported: assert property (@(posedge SYS_CLK) disable iff (RESET)
    loop_state == LOOP_ACQUIRE && loop_run && !saturated && ref_tick && lock_cnt == `LOCK_REF_TICKS - `LOCK_CNT_ONE
    |=> loop_lock_flag) else $error("lock not reported");
  a_no_lock_unrun: assert property (@(posedge SYS_CLK) disable iff (RESET)
    !loop_run || saturated |=> !loop_lock_flag) else $error("lock flag set while off or saturated");
  a_bit_op_refused: assert property (@(posedge SYS_CLK) disable iff (RESET)
    IO_REQ.bit_set && !IO_REQ.wr && IO_REQ.addr == `ADDR_LOOP_CTRL |=> $stable(loop_enable_bit))
    else $error("bit operation changed a high register");
  a_async_wake: assert property (@(posedge SYS_CLK) disable iff (RESET)
    !EXT_INT_N [*3] |=> ASYNC_WAKE) else $error("pin level missed while peripheral clock halted");
  a_timer_direct: assert property (@(posedge SYS_CLK) disable iff (RESET)
    pck_direct && FAST_CLOCK_TICK |=> TIMER1_CLOCK_TICK) else $error("timer lost a direct fast tick");
  a_fast_silent_off: assert property (@(posedge SYS_CLK) disable iff (RESET)
    loop_state == LOOP_OFF [*2] |-> !FAST_CLOCK_TICK) else $error("fast clock ticks while loop off");
  a_source_select: assert property (@(posedge SYS_CLK) disable iff (RESET)
    fuse_sync[1] != `FUSE_PROGRAMMED |=> !SYS_SOURCE_IS_LOOP) else $error("loop chosen with fuse unprogrammed");

endmodule

// >>> include/clk_tree_cfg.svh
/*
  Constants of the clock tree and fast clock loop: register offsets, bit
  positions, reset values and oscillator model words.
  Assumes a 125 MHz SYS_CLK; all frequency words are phase increments of a
  24-bit accumulator on that clock.
*/
`ifndef CLK_TREE_CFG_SVH
`define CLK_TREE_CFG_SVH

// I/O space locations and the top of the bit-accessible range.
`define ADDR_LOOP_CTRL 6'h29
`define ADDR_RC_TRIM 6'h31
`define ADDR_BIT_LIMIT 6'h1F

// Field positions of the loop control and status register.
`define LOCK_BIT 0
`define LOOP_EN_BIT 1
`define PCK_DIRECT_BIT 2

// Reset values.
`define CTRL_RESET 1'b0
`define TRIM_RESET 8'h80
`define READ_IDLE 8'h00

// Fuse level that means programmed, and the source code selecting the loop.
`define FUSE_PROGRAMMED 1'b0
`define SOURCE_FUSES_LOOP 4'h1

// Accumulator words at 125 MHz: 2^24 * f / 125 MHz.
`define REF_BASE_WORD 24'h018C4A
`define FAST_MULT_SHIFT 6
`define FAST_SAT_WORD 24'h8F5C29

// Reference periods the loop needs before it reports lock.
`define LOCK_REF_TICKS 8'h40
`define LOCK_CNT_ZERO 8'h00
`define LOCK_CNT_ONE 8'h01

// Divide ratio minus one of the prescaled fast clock for the second timer.
`define TIMER_PRESCALE_MAX 2'h3
`define PRESCALE_ZERO 2'h0
`define PRESCALE_ONE 2'h1

`endif

// >>> include/clk_tree_pkg.sv
/*
  Types of the clock tree and fast clock loop.
  Assumes clk_tree_cfg.svh supplies all numeric constants.
*/
package clk_tree_pkg;

  typedef enum logic [2:0] {
    SLEEP_ACTIVE = 3'h0,
    SLEEP_IDLE = 3'h1,
    SLEEP_ADC_NR = 3'h2,
    SLEEP_POWER_DOWN = 3'h3,
    SLEEP_STANDBY = 3'h4
  } sleep_mode_type;

  typedef enum logic [3:0] {
    LOOP_OFF = 4'h1,
    LOOP_ACQUIRE = 4'h2,
    LOOP_LOCKED = 4'h4,
    LOOP_SATURATED = 4'h8
  } loop_state_type;

  typedef struct packed {
    logic core;
    logic program_memory;
    logic peripheral;
    logic converter;
    logic rc_osc;
  } domain_gate_type;

  typedef struct packed {
    logic rd;
    logic wr;
    logic bit_set;
    logic bit_clr;
    logic [2:0] bit_sel;
    logic [5:0] addr;
    logic [7:0] wdata;
  } io_request_type;

endpackage

// >>> verification/clock_consumer_model.sv
/*
  Far-side consumer of the clock tree: counts fast, timer and interrupt pulses.
  Assumes every pulse is one SYS_CLK cycle wide and clr is driven by the bench.
*/
`timescale 1ns/1ps
module clock_consumer_model (
  // Clock and window clear
  input wire logic clk,
  input wire logic clr,
  // Pulses from the clock tree
  input wire logic fast_tick,
  input wire logic timer_tick,
  input wire logic int_event,
  // Pulse counts of the current window
  output logic [15:0] n_fast,
  output logic [15:0] n_timer,
  output logic [15:0] n_int
);
  // The timer takes whichever clock form is selected; counting both lets the bench compare ratios.
  always_ff @(posedge clk) begin
    if (clr) begin
      n_fast <= 16'h0000;
      n_timer <= 16'h0000;
      n_int <= 16'h0000;
    end else begin
      n_fast <= n_fast + {15'h0000, fast_tick};
      n_timer <= n_timer + {15'h0000, timer_tick};
      n_int <= n_int + {15'h0000, int_event};
    end
  end
endmodule

// >>> verification/clock_tree_and_fast_pll_bench.sv
/*
  Self-checking bench of the clock tree and fast clock loop.
  Assumes the 125 MHz SYS_CLK, reads answered one cycle after rd.
*/
`timescale 1ns/1ps
`include "clk_tree_cfg.svh"
module clock_tree_and_fast_pll_bench;
  import clk_tree_pkg::*;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  io_request_type req = '0;
  sleep_mode_type mode = SLEEP_ACTIVE;
  logic fuse = 1'b1;
  logic [3:0] src_fuses = 4'h2;
  logic ext_int_n = 1'b1;
  logic clr = 1'b0;
  logic rd_q = 1'b0;
  logic [7:0] rdata;
  logic [7:0] t;
  logic [31:0] r;
  domain_gate_type gates;
  logic src_loop, wake, int_ev, fast_tick, t1_tick, fpc;
  logic [15:0] n_fast, n_timer, n_int;
  logic [7:0] exp_q[$];
  logic [4:0] exp_g [5] = '{5'h1F, 5'h07, 5'h03, 5'h00, 5'h00};
  logic [4:0] care [5] = '{5'h1F, 5'h1F, 5'h1F, 5'h19, 5'h19};
  logic [31:0] seed = 32'h0B8F;
  int n_mismatch = 0;
  int num_checks = 0;
  int i;

  always #4 sys_clk = ~sys_clk;

  clock_tree_and_fast_pll uut (.SYS_CLK(sys_clk), .RESET(reset), .IO_REQ(req), .IO_RDATA(rdata),
    .SLEEP_MODE(mode), .FAST_CLOCK_SELECT_FUSE(fuse), .CLOCK_SOURCE_FUSES(src_fuses), .EXT_INT_N(ext_int_n),
    .DOMAIN_GATES(gates), .SYS_SOURCE_IS_LOOP(src_loop), .ASYNC_WAKE(wake), .EXT_INT_EVENT(int_ev),
    .FAST_PERIPHERAL_CLOCK(fpc), .FAST_CLOCK_TICK(fast_tick), .TIMER1_CLOCK_TICK(t1_tick));
  clock_consumer_model partner (.clk(sys_clk), .clr(clr), .fast_tick(fast_tick), .timer_tick(t1_tick),
    .int_event(int_ev), .n_fast(n_fast), .n_timer(n_timer), .n_int(n_int));

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] expd);
    num_checks++;
    if (seen !== expd) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, expd);
    end
  endtask

  // Accumulator phase is unknown at window start, so counts may differ by one.
  task automatic near(input logic [15:0] s, input logic [15:0] e);
    check((s === e + 16'h0001 || s === e - 16'h0001) ? e : s, e);
  endtask

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [15:0] fexp(input logic [7:0] trim, input int n);
    logic [31:0] w;
    w = ({8'h00, `REF_BASE_WORD} + {16'h0000, trim, 8'h00}) << `FAST_MULT_SHIFT;
    if (w > {8'h00, `FAST_SAT_WORD}) begin
      w = {8'h00, `FAST_SAT_WORD};
    end
    return 16'((64'(w) * n) >> 24);
  endfunction

  task automatic io(input logic r, input logic w, input logic [5:0] a, input logic [7:0] d,
                    input logic bs, input logic bc);
    @(negedge sys_clk);
    req = {r, w, bs, bc, d[2:0], a, d};
    @(negedge sys_clk);
    req = '0;
  endtask

  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    io(1'b1, 1'b0, a, 8'h00, 1'b0, 1'b0);
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    io(1'b0, 1'b1, a, d, 1'b0, 1'b0);
  endtask

  task automatic wait_lock(input logic want);
    for (int k = 0; k < 200; k++) begin
      repeat (60) @(negedge sys_clk);
      io(1'b1, 1'b0, `ADDR_LOOP_CTRL, 8'h00, 1'b0, 1'b0);
      if (rdata[`LOCK_BIT] === want) begin
        return;
      end
    end
    n_mismatch++;
    final_report();
  endtask

  task automatic measure(input int n);
    @(negedge sys_clk);
    clr = 1'b1;
    @(negedge sys_clk);
    clr = 1'b0;
    repeat (n) @(negedge sys_clk);
  endtask

  // Polling reads push no note, so only noted reads are compared.
  always @(posedge sys_clk) begin
    if (rd_q && exp_q.size() > 0) begin
      check({8'h00, rdata}, {8'h00, exp_q.pop_front()});
    end
    rd_q <= req.rd;
  end

  initial begin
    repeat (100000) @(negedge sys_clk);
    n_mismatch++;
    final_report();
  end

  initial begin
    repeat (5) @(negedge sys_clk);
    reset = 1'b0;
    rd(`ADDR_LOOP_CTRL, 8'h00);
    rd(`ADDR_RC_TRIM, `TRIM_RESET);
    rd(6'h2A, `READ_IDLE);
    io(1'b0, 1'b0, `ADDR_LOOP_CTRL, 8'h01, 1'b1, 1'b0);
    io(1'b0, 1'b0, `ADDR_RC_TRIM, 8'h07, 1'b0, 1'b1);
    rd(`ADDR_LOOP_CTRL, 8'h00);
    rd(`ADDR_RC_TRIM, `TRIM_RESET);
    measure(200);
    check(n_fast, 16'h0000);
    check({15'h0000, fpc}, 16'h0000);
    for (i = 0; i < 3; i++) begin
      r = rnd();
      t = 8'h60 + {3'h0, r[4:0]};
      wr(`ADDR_RC_TRIM, t);
      rd(`ADDR_RC_TRIM, t);
    end
    wr(`ADDR_RC_TRIM, 8'h80);
    wr(`ADDR_LOOP_CTRL, 8'h06);
    wait_lock(1'b1);
    rd(`ADDR_LOOP_CTRL, 8'h07);
    measure(1000);
    near(n_fast, fexp(8'h80, 1000));
    near(n_timer, n_fast);
    wr(`ADDR_RC_TRIM, 8'h70);
    measure(1000);
    near(n_fast, fexp(8'h70, 1000));
    rd(`ADDR_LOOP_CTRL, 8'h07);
    wr(`ADDR_LOOP_CTRL, 8'h02);
    measure(1000);
    near(n_timer, n_fast >> 2);
    wr(`ADDR_RC_TRIM, 8'hC0);
    wait_lock(1'b0);
    rd(`ADDR_LOOP_CTRL, 8'h02);
    measure(1000);
    near(n_fast, fexp(8'hC0, 1000));
    wr(`ADDR_RC_TRIM, 8'h80);
    wr(`ADDR_LOOP_CTRL, 8'h00);
    repeat (3) @(negedge sys_clk);
    rd(`ADDR_LOOP_CTRL, 8'h00);
    fuse = 1'b0;
    src_fuses = 4'h1;
    wait_lock(1'b1);
    check({15'h0000, src_loop}, 16'h0001);
    measure(500);
    near(n_fast, fexp(8'h80, 500));
    r = rnd();
    src_fuses = r[3:0] | 4'h2;
    repeat (3) @(negedge sys_clk);
    check({15'h0000, src_loop}, 16'h0000);
    for (i = 0; i < 5; i++) begin
      mode = sleep_mode_type'(i);
      repeat (2) @(negedge sys_clk);
      check({11'h000, gates & care[i]}, {11'h000, exp_g[i] & care[i]});
    end
    measure(200);
    check(n_fast, 16'h0000);
    check({15'h0000, fpc}, 16'h0000);
    ext_int_n = 1'b0;
    repeat (8) @(negedge sys_clk);
    check({15'h0000, wake}, 16'h0001);
    check(n_int, 16'h0000);
    ext_int_n = 1'b1;
    mode = SLEEP_ACTIVE;
    repeat (4) @(negedge sys_clk);
    rd(`ADDR_LOOP_CTRL, 8'h00);
    measure(2);
    ext_int_n = 1'b0;
    repeat (8) @(negedge sys_clk);
    check(n_int, 16'h0001);
    repeat (4) @(negedge sys_clk);
    final_report();
  end
endmodule
